/* File: bpc_pkg.sv */
package bpc_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SETTING = 8'h04;
  localparam logic [7:0] OFF_PERIOD = 8'h08;
  localparam logic [7:0] OFF_DUTY = 8'h0c;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  localparam int CTRL_RUN = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_POL_LO = 3;
  localparam int CTRL_DIV_LO = 5;
  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [6:0] RST_CTRL = 7'h00;
  localparam logic [6:0] RST_SETTING = 7'h00;
  localparam logic [7:0] RST_PERIOD = 8'h00;
  localparam logic [9:0] RST_DUTY = 10'h000;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 5;
  localparam int DB_UNIT_NS = 20;
  localparam int DB_UNIT_CYCLES = (DB_UNIT_NS + CLK_NS - 1) / CLK_NS;
  // ----------------------------------------
  // Enumerations
  // ----------------------------------------
  typedef enum logic [1:0] {
    single_out, half_bridge, full_forward, full_reverse
  } bpc_mode_e;
  typedef enum logic [1:0] {
    both_pairs_active_high, pair_ac_high_pair_bd_low,
    pair_ac_low_pair_bd_high, both_pairs_active_low
  } bpc_pol_e;
  typedef enum logic [1:0] {
    prescale_none, prescale_by_four, prescale_by_sixteen, prescale_by_sixty_four
  } bpc_div_e;
endpackage

/* File: bpc_deadband.sv */
`timescale 1ns/100ps
module bpc_deadband (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic raw,
  input wire logic [6:0] delay,
  output logic act_a,
  output logic act_b
);
  import bpc_pkg::*;

  logic cur; // Level currently steered to the bridge
  logic [8:0] cnt; // Remaining dead cycles
  logic [8:0] gap; // Dead cycles for the programmed delay

  // Four clocks per delay unit; the cast keeps the product to the counter width
  assign gap = 9'(delay * DB_UNIT_CYCLES);

  // ----------------------------------------
  // Dead band sequencer
  // ----------------------------------------
  // dead band gap
  // Both sides drop on every edge unless the delay is zero, so they never overlap
  // The edge cycle itself is the first dead cycle, so the gap is exactly the delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= 1'b0;
      cnt <= 9'h000;
      act_a <= 1'b0;
      act_b <= 1'b0;
    end else if (!en) begin
      // Idle: both sides inactive
      cur <= 1'b0;
      cnt <= 9'h000;
      act_a <= 1'b0;
      act_b <= 1'b0;
    end else if (raw != cur) begin
      cur <= raw;
      if (gap == 9'h000) begin
        // No dead band: both sides swap on the same edge
        cnt <= 9'h000;
        act_a <= raw;
        act_b <= ~raw;
      end else begin
        // Edge: open the gap
        cnt <= gap - 9'h001;
        act_a <= 1'b0;
        act_b <= 1'b0;
      end
    end else if (cnt != 9'h000) begin
      cnt <= cnt - 9'h001;
    end else begin
      act_a <= cur;
      act_b <= ~cur;
    end
  end
endmodule

/* File: bpc_core.sv */
`timescale 1ns/100ps
module bpc_core #(
  parameter bit HAS_PRESCALE_BY_SIXTY_FOUR = 1'b1 // Some variants lack the 64 prescale
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe
);
  import bpc_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [6:0] ctrl; // Run, mode, polarity, prescale
  logic [6:0] setting; // Mask or dead band
  logic [7:0] period; // Period count
  logic [9:0] duty; // Active time
  logic restart; // Pulse: counter restart on control write
  logic wr_en; // Access phase write
  logic setup; // Setup phase

  // Field views
  logic run;
  bpc_mode_e mode;
  bpc_pol_e pol;
  bpc_div_e div;
  assign run = ctrl[CTRL_RUN];
  assign mode = bpc_mode_e'(ctrl[CTRL_MODE_LO +: 2]);
  assign pol = bpc_pol_e'(ctrl[CTRL_POL_LO +: 2]);
  assign div = bpc_div_e'(ctrl[CTRL_DIV_LO +: 2]);

  // Counter state
  logic [5:0] pre; // Prescale counter
  logic tick; // Prescaled step
  logic [7:0] tmr; // Period counter
  logic [1:0] q; // Extra low-order bits
  logic raw; // Modulated level before steering
  logic db_a; // Half mode A after dead band
  logic db_b; // Half mode B after dead band
  logic [3:0] used; // Pins owned by the modulator
  logic [3:0] act; // Active state per pin, D-C-B-A
  logic [3:0] inv; // Pins that are active low

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;

  // Unmapped offsets answer with an error
  function automatic logic mapped(input logic [7:0] a);
    mapped = (a == OFF_CTRL) || (a == OFF_SETTING) || (a == OFF_PERIOD) ||
             (a == OFF_DUTY) || (a == OFF_STATUS);
  endfunction

  // Prescale limit, one less than the division
  // prescale ratios
  function automatic logic [5:0] div_last(input bpc_div_e d);
    unique case (d)
      prescale_none: div_last = 6'h00;
      prescale_by_four: div_last = 6'h03;
      prescale_by_sixteen: div_last = 6'h0f;
      prescale_by_sixty_four: div_last = HAS_PRESCALE_BY_SIXTY_FOUR ? 6'h3f : 6'h0f;
    endcase
  endfunction

  // ----------------------------------------
  // APB answer
  // ----------------------------------------
  // Answer in the first access cycle; registered outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped(paddr);
      prdata <= 32'h0000_0000;
      if (setup && !pwrite) begin
        unique case (paddr)
          OFF_CTRL: prdata <= {25'h0, ctrl};
          OFF_SETTING: prdata <= {25'h0, setting};
          OFF_PERIOD: prdata <= {24'h0, period};
          OFF_DUTY: prdata <= {22'h0, duty};
          OFF_STATUS: prdata <= {13'h0, raw, q, tmr, pin_oe, pin_out};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // setting unused in full modes, stored only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= RST_CTRL;
      setting <= RST_SETTING;
      period <= RST_PERIOD;
      duty <= RST_DUTY;
      restart <= 1'b0;
    end else begin
      restart <= 1'b0;
      if (wr_en && !pslverr) begin
        unique case (paddr)
          // Control write restarts the counter, like a fresh command
          OFF_CTRL: begin
            ctrl <= pwdata[6:0];
            restart <= 1'b1;
          end
          OFF_SETTING: setting <= pwdata[6:0];
          OFF_PERIOD: period <= pwdata[7:0];
          OFF_DUTY: duty <= pwdata[9:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Prescaler
  // ----------------------------------------
  // prescaled step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre <= 6'h00;
      tick <= 1'b0;
    end else if (!run || restart) begin
      pre <= 6'h00;
      tick <= 1'b0;
    end else if (pre >= div_last(div)) begin
      pre <= 6'h00;
      tick <= 1'b1;
    end else begin
      pre <= pre + 6'h01;
      tick <= 1'b0;
    end
  end

  // ----------------------------------------
  // Period counter and compare
  // ----------------------------------------
  // extended counter wrap
  // A period lowered below the count wraps at once, no long overrun
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr <= 8'h00;
      q <= 2'h0;
    end else if (!run || restart) begin
      tmr <= 8'h00;
      q <= 2'h0;
    end else if (tick) begin
      if (q == 2'h3) begin
        q <= 2'h0;
        tmr <= (tmr >= period) ? 8'h00 : tmr + 8'h01;
      end else begin
        q <= q + 2'h1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw <= 1'b0;
    end else begin
      raw <= run && (duty > {tmr, q});
    end
  end

  // ----------------------------------------
  // Dead band
  // ----------------------------------------
  // half mode gap
  bpc_deadband u_db (
    .pclk(pclk),
    .presetn(presetn),
    .en(run && mode == half_bridge),
    .raw(raw),
    .delay(setting),
    .act_a(db_a),
    .act_b(db_b)
  );

  // ----------------------------------------
  // Steering
  // ----------------------------------------
  // pin sets per mode
  always_comb begin
    used = 4'h0;
    act = 4'h0;
    unique case (mode)
      single_out: begin
        used = setting[3:0];
        act = setting[3:0] & {4{raw}};
      end
      half_bridge: begin
        used = 4'b0011;
        act = {2'b00, db_b, db_a};
      end
      full_forward: begin
        used = 4'b1111;
        act = {raw, 2'b00, 1'b1};
      end
      full_reverse: begin
        used = 4'b1111;
        act = {1'b0, 1'b1, raw, 1'b0};
      end
    endcase
  end

  assign inv = {pol[0], pol[1], pol[0], pol[1]};

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  // Registered so pins never glitch on a mode change
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 4'h0;
      pin_oe <= 4'h0;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (run && used[i]) begin
          pin_out[i] <= act[i] ^ inv[i];
          pin_oe[i] <= 1'b1;
        end else begin
          pin_out[i] <= gpio_out[i];
          pin_oe[i] <= gpio_oe[i];
        end
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_off_gpio: assert property (!run |=> pin_oe == $past(gpio_oe) &&
    pin_out == $past(gpio_out)) else $error("off pins not general purpose");
  a_half_apart: assert property (run && mode == half_bridge |=>
    !((pin_out[0] ^ $past(inv[0])) && (pin_out[1] ^ $past(inv[1]))))
    else $error("half bridge sides active together");
  a_fwd_steer: assert property (run && mode == full_forward |=>
    pin_oe == 4'hf && pin_out[0] == ~$past(inv[0]) && pin_out[1] == $past(inv[1]) &&
    pin_out[2] == $past(inv[2])) else $error("forward steering wrong");
  a_rev_steer: assert property (run && mode == full_reverse |=>
    pin_out[2] == ~$past(inv[2]) && pin_out[0] == $past(inv[0]) &&
    pin_out[3] == $past(inv[3])) else $error("reverse steering wrong");
  a_duty_zero: assert property (duty == 10'h000 |=> !raw)
    else $error("zero duty produced active output");
  a_period_wrap: assert property (tick && q == 2'h3 && tmr >= period &&
    run && !restart |=> tmr == 8'h00 && q == 2'h0) else $error("period did not wrap");
  a_div_four: assert property (tick && div == prescale_by_four |=>
    !tick [*3]) else $error("prescale by four too fast");
  a_single_oe: assert property (run && mode == single_out |=>
    pin_oe == ($past(setting[3:0]) | ($past(gpio_oe) & ~$past(setting[3:0]))))
    else $error("single mode enables wrong");
  a_half_pins: assert property (run && mode == half_bridge |=>
    pin_oe[3:2] == $past(gpio_oe[3:2])) else $error("half mode took C or D");

  c_single_all: cover property (run && mode == single_out && setting[3:0] == 4'hf && raw);
  c_half_run: cover property (run && mode == half_bridge && $rose(db_a));
  c_fwd_run: cover property (run && mode == full_forward && $fell(raw));
  c_slv_err: cover property (pready && pslverr);
endmodule

/* File: bpc_load.sv */
`timescale 1ns/100ps
// ----
// Bridge load model
// ----
module bpc_load (
  input wire logic pclk,
  input wire logic watch,
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe,
  input wire logic [3:0] act_hi,
  output logic [3:0] line,
  output int shoot
);
  // Undriven lines rest at the inactive level through their pull resistors
  assign line = (pin_oe & pin_out) | (~pin_oe & ~act_hi);
  initial shoot = 0;
  always @(posedge pclk) begin
    if (watch && line[0] == act_hi[0] && line[1] == act_hi[1]) begin
      shoot <= shoot + 1;
    end
  end
endmodule

/* File: tb_top.sv */
`timescale 1ns/100ps
module tb_top;
  import bpc_pkg::*;
  // ----
  // Signals
  // ----
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, watch;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] gpio_out, gpio_oe, pin_out, pin_oe, act_hi, line, m;
  int shoot, mismatches, checks, c;
  bpc_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .pin_out(pin_out),
    .pin_oe(pin_oe));
  bpc_load load_u (.pclk(pclk), .watch(watch), .pin_out(pin_out), .pin_oe(pin_oe),
    .act_hi(act_hi), .line(line), .shoot(shoot));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // ----
  // Shared tasks
  // ----
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("mismatches %0d checks %0d", mismatches, checks);
    if (mismatches == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One APB transfer, then an idle cycle so psel is never reassigned in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cnt(input int i, input int n);
    c = 0;
    repeat (n) begin
      @(posedge pclk);
      if (pin_out[i] === 1'b1) c++;
    end
  endtask
  function automatic logic [31:0] ctl(input int md, input int p, input int dv);
    return 32'(1 + md * 2 + p * 8 + dv * 32);
  endfunction
  // ----
  // Scenarios
  // ----
  task automatic t_regs();
    apb(1'b0, OFF_CTRL, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, OFF_PERIOD, 32'hffffffff);
    apb(1'b0, OFF_PERIOD, 32'h0);
    chk(rd, 32'hff);
    apb(1'b1, OFF_DUTY, 32'hffffffff);
    apb(1'b0, OFF_DUTY, 32'h0);
    chk(rd, 32'h3ff);
    apb(1'b1, OFF_SETTING, 32'hffffffff);
    apb(1'b0, OFF_SETTING, 32'h0);
    chk(rd, 32'h7f);
    apb(1'b0, 8'h14, 32'h0);
    chk(err, 1'b1);
  endtask
  task automatic t_single();
    apb(1'b1, OFF_PERIOD, 32'h0);
    apb(1'b1, OFF_SETTING, 32'h5);
    apb(1'b1, OFF_CTRL, ctl(0, 0, 0));
    repeat (8) @(posedge pclk);
    chk(pin_oe, 4'h5);
    chk(pin_out, 4'h5);
    gpio_out <= 4'ha;
    gpio_oe <= 4'ha;
    repeat (3) @(posedge pclk);
    chk({pin_oe, pin_out}, 8'hff);
  endtask
  // Full bridge in both directions, every polarity code
  task automatic t_full();
    apb(1'b1, OFF_SETTING, 32'h0);
    for (int md = 2; md < 4; md++) begin
      for (int p = 0; p < 4; p++) begin
        act_hi <= ~{p[0], p[1], p[0], p[1]};
        apb(1'b1, OFF_CTRL, ctl(md, p, 0));
        repeat (8) @(posedge pclk);
        m = (md == 2) ? 4'b1001 : 4'b0110;
        chk(pin_out, 4'((m & act_hi) | (~m & ~act_hi)));
        chk(pin_oe, 4'hf);
      end
    end
  endtask
  task automatic t_half();
    act_hi <= 4'hf;
    gpio_oe <= 4'h0;
    apb(1'b1, OFF_PERIOD, 32'h3);
    apb(1'b1, OFF_DUTY, 32'h8);
    apb(1'b1, OFF_SETTING, 32'h1);
    apb(1'b1, OFF_CTRL, ctl(1, 0, 0));
    // Watch only once the full bridge setup of the last scenario is gone
    watch <= 1'b1;
    repeat (40) @(posedge pclk);
    cnt(0, 32);
    chk(c, 8);
    cnt(1, 32);
    chk(c, 8);
    chk(pin_oe, 4'h3);
    chk(shoot, 0);
    watch <= 1'b0;
  endtask
  // Duty against period for each prescale code
  task automatic t_div();
    apb(1'b1, OFF_SETTING, 32'h1);
    apb(1'b1, OFF_PERIOD, 32'h1);
    apb(1'b1, OFF_DUTY, 32'h3);
    for (int d = 0; d < 4; d++) begin
      apb(1'b1, OFF_CTRL, ctl(0, 0, d));
      repeat (20) @(posedge pclk);
      cnt(0, 16 << (2 * d));
      chk(c, 6 << (2 * d));
    end
    apb(1'b1, OFF_DUTY, 32'h0);
    // Pins trail the duty write by two clocks
    repeat (4) @(posedge pclk);
    cnt(0, 20);
    chk(c, 0);
  endtask
  task automatic t_off();
    apb(1'b1, OFF_CTRL, 32'h0);
    gpio_out <= 4'h5;
    gpio_oe <= 4'h3;
    repeat (4) @(posedge pclk);
    chk({pin_oe, pin_out}, 8'h35);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd, 32'h35);
  endtask
  // ----
  // Main sequence and watchdog
  // ----
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, watch} = '0;
    {gpio_out, gpio_oe} = 8'h0;
    act_hi = 4'hf;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // only this modulator is ever started
    t_regs();
    t_single();
    t_full();
    t_half();
    t_div();
    t_off();
    finish_test();
  end
  initial begin
    #100000;
    mismatches++;
    finish_test();
  end
endmodule
